// ### rtl/brk_pkg.sv
package brk_pkg;
  // Byte addresses of the word-aligned registers
  localparam logic [3:0] ADDR_HIGH   = 4'h0;
  localparam logic [3:0] ADDR_LOW    = 4'h4;
  localparam logic [3:0] ADDR_CTRL   = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hc;
  localparam logic [3:0] ADDR_CLEAR  = 4'h0;
  localparam logic [3:0] ADDR_IRQEN  = 4'h4;
  localparam logic       BANK_MAIN   = 1'b0;
  localparam logic       BANK_IRQ    = 1'b1;
  // Control register field positions
  localparam int         CTRL_FLAG   = 3;
  localparam int         CTRL_PULSE  = 2;
  localparam int         CTRL_EN     = 1;
  // Status and interrupt layout: bit 0 is the match event
  localparam int         EV_MATCH    = 0;
  localparam logic [7:0] ADDR_RESET  = 8'h00;
  localparam logic [31:0] UNMAPPED   = 32'h0000_0000;
endpackage : brk_pkg

// ### rtl/address_breakpoint_unit.sv
// Local design decisions: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ns
// Operation
// - Fetch address equal to breakpoint raises event
// - External data access match raises event too
// - Breakpoint split into high and low bytes
// - Enable and pulse bits govern event action
// - Latched flag unless pulse select is set
// - Writing one to flag clears it
// - Pin always mirrors the match flag
module address_breakpoint_unit (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [15:0] core_addr,
  input  wire logic        fetch_valid,
  input  wire logic        ext_data_valid,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             match_pin,
  output logic             irq
);
  import brk_pkg::*;

  logic [7:0]  break_address_high_q;
  logic [7:0]  break_address_low_q;
  logic        match_enable_q;
  logic        pulse_select_q;
  logic        flag_q;
  logic        status_q;
  logic        irq_en_q;
  logic        ack_q;
  logic        waitrequest_q;
  logic [31:0] rdata_q;

  // Register select tests the bank bit and the byte offset
  function automatic logic hit(input logic [4:0] a, input logic bank,
                               input logic [3:0] off);
    return (a[4] == bank) && (a[3:0] == off);
  endfunction : hit

  // Address decode; one wait cycle so readdata comes from a flop
  wire         req       = (avs_read | avs_write) & ~ack_q;
  // Writes land on the edge where waitrequest is seen low, never earlier
  wire         wr        = avs_write & ack_q & avs_byteenable[0];
  wire         sel_high  = hit(avs_address, BANK_MAIN, ADDR_HIGH);
  wire         sel_low   = hit(avs_address, BANK_MAIN, ADDR_LOW);
  wire         sel_ctrl  = hit(avs_address, BANK_MAIN, ADDR_CTRL);
  wire         sel_stat  = hit(avs_address, BANK_MAIN, ADDR_STATUS);
  wire         sel_clr   = hit(avs_address, BANK_IRQ, ADDR_CLEAR);
  wire         sel_ien   = hit(avs_address, BANK_IRQ, ADDR_IRQEN);
  wire         wr_high   = wr & sel_high;
  wire         wr_low    = wr & sel_low;
  wire         wr_ctrl   = wr & sel_ctrl;
  wire         wr_clr    = wr & sel_clr;
  wire         wr_ien    = wr & sel_ien;

  // Compare one 16-bit address for both access kinds
  wire [15:0]  bp_addr   = {break_address_high_q, break_address_low_q};
  wire         addr_eq   = core_addr == bp_addr;
  wire         fetch_hit = fetch_valid & addr_eq;
  wire         ext_hit   = ext_data_valid & addr_eq;
  // A disabled unit ignores matches but keeps a latched flag
  wire         event_hit = (fetch_hit | ext_hit) & match_enable_q;
  wire         flag_clr  = wr_ctrl & avs_writedata[CTRL_FLAG];
  wire         stat_clr  = wr_clr & avs_writedata[EV_MATCH];
  // Set beats clear so a match during the clear write survives
  wire         flag_d    = pulse_select_q ? event_hit
                           : (event_hit | (flag_q & ~flag_clr));
  wire         status_d  = event_hit | (status_q & ~stat_clr);

  // Read path; the clear register is write-only and reads as zero
  wire [31:0]  ctrl_rd   = {28'h0, flag_q, pulse_select_q,
                            match_enable_q, 1'b0};
  wire [31:0]  rd_mux    = sel_high ? {24'h0, break_address_high_q} :
                           sel_low  ? {24'h0, break_address_low_q}  :
                           sel_ctrl ? ctrl_rd                       :
                           sel_stat ? {31'h0, status_q}             :
                           sel_ien  ? {31'h0, irq_en_q}             :
                           UNMAPPED;

  // Bus handshake: waitrequest drops for exactly one edge per request
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ack_q         <= 1'b0;
      waitrequest_q <= 1'b1;
      rdata_q       <= 32'h0;
    end else begin
      ack_q         <= req;
      waitrequest_q <= ~req;
      rdata_q       <= (avs_read & ~ack_q) ? rd_mux : rdata_q;
    end
  end

  // Software registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      break_address_high_q <= ADDR_RESET;
      break_address_low_q  <= ADDR_RESET;
      match_enable_q       <= 1'b0;
      pulse_select_q       <= 1'b0;
      irq_en_q             <= 1'b0;
    end else begin
      if (wr_high) break_address_high_q <= avs_writedata[7:0];
      if (wr_low)  break_address_low_q  <= avs_writedata[7:0];
      if (wr_ctrl) begin
        match_enable_q <= avs_writedata[CTRL_EN];
        pulse_select_q <= avs_writedata[CTRL_PULSE];
      end
      if (wr_ien) irq_en_q <= avs_writedata[EV_MATCH];
    end
  end

  // Flag, pin copy, sticky status and interrupt
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      flag_q    <= 1'b0;
      match_pin <= 1'b0;
      status_q  <= 1'b0;
      irq       <= 1'b0;
    end else begin
      flag_q    <= flag_d;
      match_pin <= flag_d;
      status_q  <= status_d;
      irq       <= status_d & irq_en_q;
    end
  end

  // Outputs come straight from flops
  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = waitrequest_q;

  // Checks on the breakpoint path and the register bus

  // The pin is a second copy of the flag, never a gated one
  a_pin_mirror: assert property (
    @(posedge sys_clk) disable iff (!resetn) match_pin == flag_q)
    else $error("pin differs from flag");

  // With matching off, a clear flag stays clear
  a_enable_gate: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (!match_enable_q && !flag_q) |=> !flag_q)
    else $error("flag set while disabled");

  // A code fetch at the stored address raises the flag next cycle
  a_fetch_sets: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (fetch_valid && addr_eq && match_enable_q) |=> flag_q)
    else $error("fetch match missed");

  // An external data access uses the very same compare
  a_ext_sets: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (ext_data_valid && addr_eq && match_enable_q) |=> flag_q)
    else $error("data match missed");

  // In latched mode only a clear write may drop the flag
  a_latch_holds: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (flag_q && !pulse_select_q && !flag_clr) |=> flag_q)
    else $error("latched flag dropped");

  // In pulse mode the flag lasts only as long as the match
  a_pulse_drops: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (pulse_select_q && !event_hit) |=> !flag_q)
    else $error("pulse flag stuck");

  // A clear write wins unless a new match lands with it
  a_clear_works: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (flag_clr && !event_hit) |=> !flag_q)
    else $error("clear ignored");

  // Each byte register takes its half of the compare address
  a_addr_split: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    wr_high |=> break_address_high_q == $past(avs_writedata[7:0]))
    else $error("high byte not stored");
  a_low_split: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    wr_low |=> break_address_low_q == $past(avs_writedata[7:0]))
    else $error("low byte not stored");

  // Enable and pulse select follow every control write
  a_ctrl_apply: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    wr_ctrl |=> match_enable_q == $past(avs_writedata[CTRL_EN]))
    else $error("enable not stored");
  a_pulse_apply: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    wr_ctrl |=> pulse_select_q == $past(avs_writedata[CTRL_PULSE]))
    else $error("pulse select not stored");

  // Every new request is answered on the very next edge
  a_bus_answer: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    req |=> !avs_waitrequest)
    else $error("request not answered");
  // The answer stands one cycle, so a held request is not taken twice
  a_wait_one: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");

  // Status stays set until software writes its clear bit
  a_status_sticky: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (status_q && !stat_clr) |=> status_q)
    else $error("status dropped");
  // The interrupt never stands without a status bit behind it
  a_irq_level: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    irq |-> status_q)
    else $error("irq without status");

  // Main scenarios the bench should reach
  c_fetch_hit: cover property (@(posedge sys_clk) disable iff (!resetn)
    fetch_hit && match_enable_q);
  c_ext_hit: cover property (@(posedge sys_clk) disable iff (!resetn)
    ext_hit && match_enable_q);
  c_pulse_mode: cover property (@(posedge sys_clk) disable iff (!resetn)
    pulse_select_q && flag_q ##1 !flag_q);
  c_clear_flag: cover property (@(posedge sys_clk) disable iff (!resetn)
    flag_q && flag_clr ##1 !flag_q);
  c_irq_raise: cover property (@(posedge sys_clk) disable iff (!resetn)
    !irq ##1 irq);
endmodule : address_breakpoint_unit

// ### bench/core_bus_model.sv
`timescale 1ns/1ns
// Core address bus; a released bus shows the inverted address
module core_bus_model (
  input  wire logic        sys_clk,
  output logic      [15:0] core_addr,
  output logic             fetch_valid,
  output logic             ext_data_valid
);
  initial begin
    core_addr   = 16'h0000;
    fetch_valid = 1'b0;
    ext_data_valid = 1'b0;
  end
  // One access cycle: kind 0 is a code fetch, kind 1 external data
  task automatic access(input logic [15:0] a, input logic kind);
    @(posedge sys_clk);
    core_addr   <= a;
    fetch_valid <= !kind;
    ext_data_valid <= kind;
    @(posedge sys_clk);
    core_addr   <= ~a;
    fetch_valid <= 1'b0;
    ext_data_valid <= 1'b0;
  endtask : access
endmodule : core_bus_model

// ### bench/test_address_breakpoint_unit.sv
`timescale 1ns/1ns
module test_address_breakpoint_unit;
  import brk_pkg::*;
  logic sys_clk, resetn, fetch_valid, ext_data_valid, avs_read, avs_write;
  logic [15:0] core_addr;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic        avs_waitrequest, match_pin, irq;
  int          fail_count = 0;
  int          checks = 0;
  core_bus_model core (.sys_clk(sys_clk), .core_addr(core_addr),
    .fetch_valid(fetch_valid), .ext_data_valid(ext_data_valid));
  address_breakpoint_unit DUT (.sys_clk(sys_clk), .resetn(resetn),
    .core_addr(core_addr), .fetch_valid(fetch_valid),
    .ext_data_valid(ext_data_valid), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .match_pin(match_pin), .irq(irq));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic check(input string s, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : check
  // Hold the request until waitrequest is sampled low; watchdog cuts hangs
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    check("wait cycles", 32'h2, n);
  endtask : bus
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check("readdata", e, q);
  endtask : rd
  // Registered outputs are looked at once the edge has landed
  task automatic pin(input logic e);
    #1;
    check("match_pin", {31'h0, e}, {31'h0, match_pin});
  endtask : pin
  task automatic give_verdict;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  // About 80 cycles are needed; a hang is cut well after that
  initial begin
    #40000;
    fail_count++;
    give_verdict();
  end
  initial begin
    {resetn, avs_read, avs_write, avs_address, avs_writedata} = '0;
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(5'h00, 32'h0);
    bus(1'b1, 5'h00, 32'h12);
    bus(1'b1, 5'h04, 32'h34);
    bus(1'b1, 5'h08, 32'h02);
    rd(5'h00, 32'h12);
    rd(5'h04, 32'h34);
    core.access(16'h1235, 1'b0); pin(1'b0);
    core.access(16'h1234, 1'b0); pin(1'b1);
    core.access(16'h0034, 1'b1); pin(1'b1);
    rd(5'h08, 32'h0a);
    bus(1'b1, 5'h08, 32'h0a); pin(1'b0);
    core.access(16'h1234, 1'b1); pin(1'b1);
    bus(1'b1, 5'h08, 32'h08);
    core.access(16'h1234, 1'b0); pin(1'b0);
    bus(1'b1, 5'h08, 32'h06);
    core.access(16'h1234, 1'b1); pin(1'b1);
    @(posedge sys_clk); pin(1'b0);
    bus(1'b1, 5'h14, 32'h1);
    rd(5'h0c, 32'h1); check("irq", 32'h1, {31'h0, irq});
    bus(1'b1, 5'h10, 32'h1);
    rd(5'h0c, 32'h0); check("irq", 32'h0, {31'h0, irq});
    rd(5'h18, 32'h0);
    bus(1'b1, 5'h14, 32'h0);
    core.access(16'h1234, 1'b0);
    rd(5'h0c, 32'h1); check("irq", 32'h0, {31'h0, irq});
    give_verdict();
  end
endmodule : test_address_breakpoint_unit
